// ==== hdl/fsl_pkg.sv ====
// Function
// R1 - Firmware write needs write-enable bit set
// R2 - Firmware erase needs write and erase enables
// R3 - Lock byte is last user flash byte
// R4 - Complement of lock byte locks pages 0..n-1
// R5 - Lock-byte page locked when any page locked
// R6 - Value 0x80 locks whole largest flash
// R7 - Unlocked ordinary pages open to everyone
// R8 - Locked pages: debug refused, unlocked firmware resets
// R9 - Locked lock page: same three-way check
// R10 - Lock byte reads follow same three-way check
// R11 - Unlocked: debug may erase lock page; firmware resets
// R12 - Debug device erase clears all, unlocks
// R13 - Written lock byte is frozen; firmware resets
// R14 - Reserved area: debug refused, firmware resets
// R15 - Flash error flag survives its reset
// R16 - Prohibited debug requests ignored without reset
// R17 - New lock byte applies after next reset
// R18 - Two keys in order arm one modification
// R19 - Page erase sets page bytes to ones
// R20 - Firmware locality judged by instruction address
package fsl_pkg;

    localparam int          ADDR_W       = 17;
    localparam int          PAGE_SHIFT   = 10;
    localparam int          PAGE_W       = ADDR_W - PAGE_SHIFT;
    localparam int          USER_PAGES   = 128;
    localparam logic [7:0]  LOCK_ERASED  = 8'hff;
    localparam logic [7:0]  LOCK_ALL     = 8'h00;
    localparam logic [7:0]  KEY_FIRST    = 8'ha5;
    localparam logic [7:0]  KEY_SECOND   = 8'hf1;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_KEY      = 8'h04;
    localparam logic [7:0]  OFS_CAUSE    = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0c;

    // Field positions
    localparam int          BIT_WR_EN    = 0;
    localparam int          BIT_ER_EN    = 1;
    localparam int          BIT_FERR     = 6;
    localparam int          BIT_ARMED    = 8;
    localparam int          BIT_DEAD     = 9;
    localparam logic [1:0]  CTRL_RESET   = 2'h0;

    typedef enum logic [1:0] {
        FSL_READ,
        FSL_WRITE,
        FSL_ERASE,
        FSL_DEV_ERASE
    } fsl_op_e;

    typedef enum logic {
        FSL_SRC_FW,
        FSL_SRC_DBG
    } fsl_src_e;

    typedef enum logic [1:0] {
        FSL_GRANT,
        FSL_REFUSE,
        FSL_FERR
    } fsl_verdict_e;

    typedef struct packed {
        fsl_src_e            src;
        fsl_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [ADDR_W-1:0]   pc;
        logic [7:0]          wdata;
    } fsl_req_s;

    typedef struct packed {
        fsl_op_e             op;
        logic [ADDR_W-1:0]   addr;
        logic [7:0]          wdata;
    } fsl_cmd_s;

endpackage

// ==== hdl/fsl_key_seq.sv ====
`timescale 1ns/1ps
module fsl_key_seq (
    input  wire logic       hclk,      // System clock
    input  wire logic       hresetn,   // Async reset, active low
    input  wire logic       key_wr,    // Key register written
    input  wire logic [7:0] key_data,  // Written key value
    input  wire logic       op_used,   // Modification consumed the keys
    input  wire logic       op_early,  // Modification tried unarmed
    output logic            armed,     // Both keys seen in order
    output logic            dead       // Locked out until reset
);
    import fsl_pkg::*;

    typedef enum logic [1:0] {
        KS_IDLE,
        KS_HALF,
        KS_ARMED,
        KS_DEAD
    } fsl_key_e;

    fsl_key_e state_q;
    fsl_key_e state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            KS_IDLE: begin
                if (op_early) begin
                    state_d = KS_DEAD;                        // [R18]
                end else if (key_wr) begin
                    state_d = (key_data == KEY_FIRST) ? KS_HALF : KS_DEAD;
                end
            end
            KS_HALF: begin
                if (op_early) begin
                    state_d = KS_DEAD;
                end else if (key_wr) begin
                    state_d = (key_data == KEY_SECOND) ? KS_ARMED : KS_DEAD;
                end
            end
            KS_ARMED: begin
                if (op_used) begin
                    state_d = KS_IDLE;                        // [R18]
                end else if (key_wr) begin
                    state_d = KS_DEAD;
                end
            end
            KS_DEAD: state_d = KS_DEAD;
            default: state_d = KS_DEAD;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= KS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign armed = (state_q == KS_ARMED);
    assign dead  = (state_q == KS_DEAD);

endmodule

// ==== hdl/fsl_top.sv ====
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module fsl_top #(
    parameter int USER_PAGES = fsl_pkg::USER_PAGES
) (
    input  wire logic                      hclk,       // System clock
    input  wire logic                      hresetn,    // Device reset, low
    input  wire logic                      por_n,      // Power-on reset, low
    input  wire logic                      hsel,       // AHB select
    input  wire logic [31:0]               haddr,      // AHB address
    input  wire logic [1:0]                htrans,     // AHB transfer type
    input  wire logic                      hwrite,     // AHB write
    input  wire logic [2:0]                hsize,      // AHB size
    input  wire logic [31:0]               hwdata,     // AHB write data
    input  wire logic                      hready,     // AHB bus ready
    output logic [31:0]                    hrdata,     // AHB read data
    output logic                           hreadyout,  // AHB slave ready
    output logic                           hresp,      // AHB response
    input  wire logic                      req_valid,  // Flash request
    input  wire fsl_pkg::fsl_req_s         req,        // Request fields
    input  wire logic [7:0]                lock_mem,   // Array lock byte
    output logic                           rsp_valid,  // Verdict pulse
    output fsl_pkg::fsl_verdict_e          rsp_code,   // Verdict
    output logic                           cmd_valid,  // Array command
    output fsl_pkg::fsl_cmd_s              cmd,        // Command fields
    output logic                           fer_reset,  // Flash error reset
    output logic                           flash_error_flag // Cause flag
);
    import fsl_pkg::*;

    localparam logic [7:0] USER_PG = 8'(USER_PAGES);
    localparam logic [PAGE_W-1:0] LOCK_PAGE = PAGE_W'(USER_PAGES - 1);
    localparam logic [ADDR_W-1:0] LOCK_ADDR =
        ADDR_W'((USER_PAGES << PAGE_SHIFT) - 1);

    function automatic logic page_locked(input logic [PAGE_W-1:0] pg,
                                         input logic [7:0] n);
        logic [7:0] p;
        p = 8'(pg);
        page_locked = (p < n) || ((pg == LOCK_PAGE) && (n != 8'h00));
    endfunction

    // Bus, control and lock state
    logic                   wr_pend_q, wr_pend_d;
    logic                   rd_pend_q, rd_pend_d;
    logic [7:0]             ofs_q, ofs_d;
    logic [31:0]            hrdata_q, hrdata_d;
    logic                   hready_q, hready_d;
    logic [1:0]             ctrl_q, ctrl_d;
    logic [7:0]             lock_q, lock_d;
    logic                   load_q, load_d;
    logic                   rsp_valid_q, rsp_valid_d;
    fsl_verdict_e           rsp_code_q, rsp_code_d;
    logic                   cmd_valid_q, cmd_valid_d;
    fsl_cmd_s               cmd_q, cmd_d;
    logic                   fer_q, fer_d;
    logic                   flag_q, flag_d;

    logic                   key_wr;
    logic                   key_armed;
    logic                   key_dead;
    logic                   op_used;
    logic                   op_early;
    logic [7:0]             n_pages;
    logic                   any_locked;
    logic                   tgt_locked;
    logic                   pc_locked;
    logic                   is_lock_pg;
    logic                   reserved;
    logic                   modify;
    fsl_verdict_e           verdict;
    logic                   addr_take;

    fsl_key_seq u_key (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .key_wr   (key_wr),
        .key_data (hwdata[7:0]),
        .op_used  (op_used),
        .op_early (op_early),
        .armed    (key_armed),
        .dead     (key_dead)
    );

    // Access check
    always_comb begin
        n_pages    = ~lock_q;                                 // [R4]
        any_locked = (lock_q != LOCK_ERASED);                 // [R5]
        tgt_locked = page_locked(req.addr[ADDR_W-1:PAGE_SHIFT],
                                 n_pages);                     // [R4] [R6]
        pc_locked  = page_locked(req.pc[ADDR_W-1:PAGE_SHIFT],
                                 n_pages);                     // [R20]
        is_lock_pg = (req.addr[ADDR_W-1:PAGE_SHIFT] == LOCK_PAGE); // [R3]
        reserved   = (8'(req.addr[ADDR_W-1:PAGE_SHIFT]) >= USER_PG);
        modify     = (req.op == FSL_WRITE) || (req.op == FSL_ERASE);
        verdict    = FSL_GRANT;
        if (req.op == FSL_DEV_ERASE) begin
            verdict = (req.src == FSL_SRC_DBG) ? FSL_GRANT : FSL_FERR; // [R12]
        end else if (reserved) begin
            verdict = (req.src == FSL_SRC_DBG) ? FSL_REFUSE
                                               : FSL_FERR;     // [R14]
        end else if (is_lock_pg && req.op == FSL_ERASE) begin
            if (req.src == FSL_SRC_FW) begin
                verdict = FSL_FERR;                           // [R11]
            end else if (any_locked) begin
                verdict = FSL_REFUSE;                         // [R11]
            end
        end else if (req.op == FSL_WRITE && req.addr == LOCK_ADDR
                     && lock_mem != LOCK_ERASED) begin
            verdict = (req.src == FSL_SRC_DBG) ? FSL_REFUSE
                                               : FSL_FERR;     // [R13]
        end else if (is_lock_pg && any_locked) begin
            if (req.src == FSL_SRC_DBG) begin
                verdict = FSL_REFUSE;                         // [R9] [R10]
            end else if (!pc_locked) begin
                verdict = FSL_FERR;                           // [R9] [R10]
            end
        end else if (!is_lock_pg && tgt_locked) begin
            if (req.src == FSL_SRC_DBG) begin
                verdict = FSL_REFUSE;                         // [R8] [R16]
            end else if (!pc_locked) begin
                verdict = FSL_FERR;                           // [R8]
            end
        end
        // Otherwise open to all requesters [R7]
        if (verdict == FSL_GRANT && req.src == FSL_SRC_FW && modify) begin
            if (!ctrl_q[BIT_WR_EN]) begin
                verdict = FSL_REFUSE;                         // [R1]
            end else if (req.op == FSL_ERASE && !ctrl_q[BIT_ER_EN]) begin
                verdict = FSL_REFUSE;                         // [R2]
            end else if (!key_armed) begin
                verdict = FSL_REFUSE;                         // [R18]
            end
        end
    end

    always_comb begin
        op_used  = 1'b0;
        op_early = 1'b0;
        if (req_valid && !fer_q && req.src == FSL_SRC_FW && modify &&
            ctrl_q[BIT_WR_EN]) begin
            op_used  = key_armed && (verdict == FSL_GRANT);
            op_early = !key_armed;                             // [R18]
        end
    end

    // Request path
    always_comb begin
        rsp_valid_d = 1'b0;
        rsp_code_d  = rsp_code_q;
        cmd_valid_d = 1'b0;
        cmd_d       = cmd_q;
        fer_d       = fer_q;
        lock_d      = lock_q;
        load_d      = 1'b0;
        if (load_q) begin
            lock_d = lock_mem;                                // [R17]
        end
        if (req_valid && !fer_q) begin
            rsp_valid_d = 1'b1;
            rsp_code_d  = verdict;
            if (verdict == FSL_GRANT) begin
                cmd_valid_d = 1'b1;
                cmd_d.op    = req.op;                         // [R19]
                cmd_d.addr  = req.addr;
                cmd_d.wdata = req.wdata;
                if (req.op == FSL_DEV_ERASE) begin
                    lock_d = LOCK_ERASED;                     // [R12]
                end
            end else if (verdict == FSL_FERR) begin
                fer_d = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rsp_valid_q <= 1'b0;
            rsp_code_q  <= FSL_GRANT;
            cmd_valid_q <= 1'b0;
            cmd_q       <= '0;
            fer_q       <= 1'b0;
            lock_q      <= LOCK_ALL;
            load_q      <= 1'b1;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_code_q  <= rsp_code_d;
            cmd_valid_q <= cmd_valid_d;
            cmd_q       <= cmd_d;
            fer_q       <= fer_d;
            lock_q      <= lock_d;
            load_q      <= load_d;
        end
    end

    // Cause flag kept across device reset
    always_comb begin
        flag_d = flag_q;
        if (wr_pend_q && ofs_q == OFS_CAUSE && hwdata[BIT_FERR]) begin
            flag_d = 1'b0;
        end
        if (fer_d && !fer_q) begin
            flag_d = 1'b1;                                    // [R15]
        end
    end

    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // AHB-Lite slave
    always_comb begin
        addr_take = hsel && hready && htrans[1];
        wr_pend_d = addr_take && hwrite;
        rd_pend_d = addr_take && !hwrite;
        ofs_d     = addr_take ? haddr[7:0] : ofs_q;
        hready_d  = !(addr_take && !hwrite);
        hrdata_d  = hrdata_q;
        ctrl_d    = ctrl_q;
        key_wr    = 1'b0;
        if (wr_pend_q) begin
            case (ofs_q)
                OFS_CTRL:  ctrl_d = hwdata[1:0];
                OFS_KEY:   key_wr = 1'b1;
                default:   ctrl_d = ctrl_q;
            endcase
        end
        if (rd_pend_q) begin
            hrdata_d = 32'h0000_0000;
            case (ofs_q)
                OFS_CTRL:   hrdata_d[1:0]     = ctrl_q;
                OFS_KEY: begin
                    hrdata_d[BIT_ARMED] = key_armed;
                    hrdata_d[BIT_DEAD]  = key_dead;
                end
                OFS_CAUSE:  hrdata_d[BIT_FERR] = flag_q;
                OFS_STATUS: begin
                    hrdata_d[7:0]  = lock_q;
                    hrdata_d[15:8] = ~lock_q;
                end
                default:    hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            ofs_q     <= 8'h00;
            hrdata_q  <= 32'h0000_0000;
            hready_q  <= 1'b1;
            ctrl_q    <= CTRL_RESET;
        end else begin
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            ofs_q     <= ofs_d;
            hrdata_q  <= hrdata_d;
            hready_q  <= hready_d;
            ctrl_q    <= ctrl_d;
        end
    end

    assign hrdata           = hrdata_q;
    assign hreadyout        = hready_q;
    assign hresp            = 1'b0;
    assign rsp_valid        = rsp_valid_q;
    assign rsp_code         = rsp_code_q;
    assign cmd_valid        = cmd_valid_q;
    assign cmd              = cmd_q;
    assign fer_reset        = fer_q;
    assign flash_error_flag = flag_q;

endmodule

// ==== test/fsl_chk.sv ====
`timescale 1ns/1ps
module fsl_chk
    import fsl_pkg::*;
(
    input  wire logic                  hclk,             // Clock
    input  wire logic                  hresetn,          // Reset, low
    input  wire logic                  hsel,             // Select
    input  wire logic [31:0]           haddr,            // Address
    input  wire logic [1:0]            htrans,           // Transfer
    input  wire logic                  hwrite,           // Write
    input  wire logic [31:0]           hwdata,           // Write data
    input  wire logic                  hready,           // Bus ready
    input  wire logic                  req_valid,        // Request
    input  wire fsl_pkg::fsl_req_s     req,              // Fields
    input  wire logic [7:0]            lock_mem,         // Lock byte
    input  wire logic                  rsp_valid,        // Verdict
    input  wire fsl_pkg::fsl_verdict_e rsp_code,         // Code
    input  wire logic                  cmd_valid,        // Command
    input  wire fsl_pkg::fsl_cmd_s     cmd,              // Fields
    input  wire logic                  fer_reset,        // Error reset
    input  wire logic                  flash_error_flag  // Cause flag
);
    logic       ph_q;
    logic       ph_d;
    logic [1:0] en_q;
    logic [1:0] en_d;

    // Shadow of the enable bits from bus writes
    always_comb begin
        ph_d = hready ? (hsel && htrans[1] && hwrite
                         && haddr[7:0] == OFS_CTRL) : ph_q;
        en_d = (ph_q && hready) ? hwdata[1:0] : en_q;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            en_q <= CTRL_RESET;
        end else begin
            ph_q <= ph_d;
            en_q <= en_d;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_req(fsl_src_e s, fsl_op_e o);
        req_valid && !fer_reset && req.src == s && req.op == o;
    endsequence

    chk_dbg_silent: assert property (
        req_valid && !fer_reset && req.src == FSL_SRC_DBG
        |=> !fer_reset && rsp_code != FSL_FERR)
        else $error("debug request caused a reset");
    chk_wr_enable: assert property (
        s_req(FSL_SRC_FW, FSL_WRITE) ##0 !en_q[BIT_WR_EN]
        |=> rsp_code != FSL_GRANT)
        else $error("write granted without enable");
    chk_er_enable: assert property (
        s_req(FSL_SRC_FW, FSL_ERASE) ##0 en_q != 2'h3
        |=> rsp_code != FSL_GRANT)
        else $error("erase granted without enables");
    chk_dev_erase: assert property (
        s_req(FSL_SRC_DBG, FSL_DEV_ERASE)
        |=> rsp_code == FSL_GRANT && cmd_valid && cmd.op == FSL_DEV_ERASE)
        else $error("device erase not granted");
    chk_flag_set: assert property (
        rsp_valid && rsp_code == FSL_FERR |=> flash_error_flag && fer_reset)
        else $error("error flag not set");
    chk_reset_cause: assert property (
        $rose(fer_reset) |-> rsp_valid && rsp_code == FSL_FERR)
        else $error("error reset without verdict");
    chk_lock_frozen: assert property (
        s_req(FSL_SRC_DBG, FSL_WRITE) ##0 req.addr == 17'h1ffff
        && lock_mem != LOCK_ERASED |=> rsp_code == FSL_REFUSE)
        else $error("written lock byte changed");
    chk_cmd_match: assert property (
        req_valid && !fer_reset ##1 rsp_valid && rsp_code == FSL_GRANT
        |-> cmd_valid && cmd.addr == $past(req.addr)
        && cmd.op == $past(req.op))
        else $error("granted command mismatch");
endmodule

bind fsl_top fsl_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .req_valid(req_valid), .req(req), .lock_mem(lock_mem),
    .rsp_valid(rsp_valid), .rsp_code(rsp_code), .cmd_valid(cmd_valid),
    .cmd(cmd), .fer_reset(fer_reset), .flash_error_flag(flash_error_flag)
);

// ==== test/fsl_flash_model.sv ====
`timescale 1ns/1ps
module fsl_flash_model
    import fsl_pkg::*;
(
    input  wire logic              hclk,      // Clock
    input  wire logic              cmd_valid, // Array command
    input  wire fsl_pkg::fsl_cmd_s cmd,       // Command fields
    output logic [7:0]             lock_mem   // Stored lock byte
);
    logic [7:0] lock_q = LOCK_ERASED;  // Non-volatile, no reset
    logic [7:0] lock_d;

    always_comb begin
        lock_d = lock_q;
        if (cmd_valid && cmd.op == FSL_DEV_ERASE) begin
            lock_d = LOCK_ERASED;
        end else if (cmd_valid && cmd.op == FSL_ERASE
                     && cmd.addr[16:10] == 7'h7f) begin
            lock_d = LOCK_ERASED;
        end else if (cmd_valid && cmd.op == FSL_WRITE
                     && cmd.addr == 17'h1ffff) begin
            lock_d = lock_q & cmd.wdata;  // Writes only clear bits
        end
    end
    always_ff @(posedge hclk) begin
        lock_q <= lock_d;
    end
    assign lock_mem = lock_q;
endmodule

// ==== test/flash_security_lock_tb.sv ====
`timescale 1ns/1ps
module flash_security_lock_tb;
    import fsl_pkg::*;
    logic         hclk = 1'b0;
    logic         hresetn, por_n, hsel, hwrite, req_valid;
    logic         hreadyout, hresp, rsp_valid, cmd_valid, fer_reset, flag;
    logic [31:0]  haddr, hwdata, hrdata, rd;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [7:0]   lock_mem;
    fsl_req_s     req;
    fsl_cmd_s     cmd;
    fsl_verdict_e rsp_code, e_now;
    fsl_verdict_e exp_q[$];
    logic [31:0]  seed = 32'ha755;
    int           errors = 0;
    int           tests_run = 0;

    initial forever #12.5 hclk = ~hclk;

    fsl_top uut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid),
        .req(req), .lock_mem(lock_mem), .rsp_valid(rsp_valid),
        .rsp_code(rsp_code), .cmd_valid(cmd_valid), .cmd(cmd),
        .fer_reset(fer_reset), .flash_error_flag(flag));
    fsl_flash_model u_flash (.hclk(hclk), .cmd_valid(cmd_valid), .cmd(cmd),
        .lock_mem(lock_mem));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [16:0] pa(input int p);
        logic [31:0] r;
        r = rnd();
        return {p[6:0], r[9:0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string n);
        ahb(1'b0, a, 32'h0);
        chk(rd, e, n);
    endtask
    task automatic arm(input logic [31:0] en);
        ahb(1'b1, OFS_CTRL, en);
        ahb(1'b1, OFS_KEY, {24'h0, KEY_FIRST});
        ahb(1'b1, OFS_KEY, {24'h0, KEY_SECOND});
    endtask
    task automatic rq(input fsl_src_e s, input fsl_op_e o,
                      input logic [16:0] a, input logic [16:0] pc,
                      input logic [7:0] d, input bit ans,
                      input fsl_verdict_e e);
        @(posedge hclk);
        req_valid <= 1'b1;
        req <= '{src: s, op: o, addr: a, pc: pc, wdata: d};
        if (ans) exp_q.push_back(e);
        @(posedge hclk);
        req_valid <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic dbg(input fsl_op_e o, input logic [16:0] a,
                       input fsl_verdict_e e);
        rq(FSL_SRC_DBG, o, a, 17'h0, 8'hff, 1'b1, e);
    endtask
    task automatic fw(input fsl_op_e o, input logic [16:0] a,
                      input logic [16:0] pc, input logic [7:0] d,
                      input fsl_verdict_e e);
        rq(FSL_SRC_FW, o, a, pc, d, 1'b1, e);
    endtask
    task automatic rst();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask

    always @(posedge hclk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0, "spare_verdict");
            end else begin
                e_now = exp_q.pop_front();
                chk(rsp_code, e_now, "rsp_code");
                chk(cmd_valid, e_now == FSL_GRANT, "cmd_valid");
            end
        end
    end

    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        end_of_test();
    end

    initial begin
        {hresetn, por_n, hsel, hwrite, req_valid} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        req = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge hclk);
        rdc(OFS_STATUS, 32'hff, "status");
        rdc(OFS_CTRL, 32'h0, "ctrl");
        rdc(OFS_CAUSE, 32'h0, "cause");
        ahb(1'b1, 8'h10, rnd());
        rdc(8'h10, 32'h0, "unmapped");
        for (int i = 0; i < 4; i++) begin
            dbg(FSL_READ, pa(i * 42), FSL_GRANT);
            fw(FSL_READ, pa(i * 42), pa(i * 30), 8'hff, FSL_GRANT);
        end
        fw(FSL_WRITE, pa(3), pa(0), 8'h3c, FSL_REFUSE);
        arm(32'h1);
        fw(FSL_WRITE, pa(4), pa(0), 8'h3c, FSL_GRANT);
        fw(FSL_WRITE, pa(4), pa(0), 8'h3c, FSL_REFUSE);
        rdc(OFS_KEY, 32'h200, "key_state");
        rst();
        arm(32'h1);
        fw(FSL_ERASE, pa(6), pa(0), 8'hff, FSL_REFUSE);
        rst();
        arm(32'h3);
        fw(FSL_ERASE, pa(6), pa(0), 8'hff, FSL_GRANT);
        arm(32'h3);
        fw(FSL_WRITE, 17'h1ffff, pa(1), 8'hfd, FSL_GRANT);
        rdc(OFS_STATUS, 32'hff, "status");
        dbg(FSL_READ, pa(0), FSL_GRANT);
        rst();
        rdc(OFS_STATUS, 32'h2fd, "status");
        dbg(FSL_READ, pa(1), FSL_REFUSE);
        dbg(FSL_READ, pa(2), FSL_GRANT);
        dbg(FSL_WRITE, pa(127), FSL_REFUSE);
        dbg(FSL_READ, 17'h1ffff, FSL_REFUSE);
        dbg(FSL_ERASE, pa(127), FSL_REFUSE);
        dbg(FSL_WRITE, 17'h1ffff, FSL_REFUSE);
        chk(fer_reset, 1'b0, "fer_reset");
        chk(hresp, 1'b0, "hresp");
        fw(FSL_READ, pa(1), pa(0), 8'hff, FSL_GRANT);
        fw(FSL_READ, 17'h1ffff, pa(1), 8'hff, FSL_GRANT);
        fw(FSL_READ, pa(0), pa(5), 8'hff, FSL_FERR);
        rq(FSL_SRC_DBG, FSL_READ, pa(2), 17'h0, 8'hff, 1'b0, FSL_GRANT);
        chk(flag, 1'b1, "flag");
        rst();
        rdc(OFS_CAUSE, 32'h40, "cause");
        ahb(1'b1, OFS_CAUSE, 32'h40);
        rdc(OFS_CAUSE, 32'h0, "cause");
        fw(FSL_READ, 17'h1ffff, pa(9), 8'hff, FSL_FERR);
        rst();
        arm(32'h3);
        fw(FSL_WRITE, 17'h1ffff, pa(0), 8'hfc, FSL_FERR);
        rst();
        fw(FSL_DEV_ERASE, pa(0), pa(0), 8'hff, FSL_FERR);
        rst();
        dbg(FSL_DEV_ERASE, pa(0), FSL_GRANT);
        rdc(OFS_STATUS, 32'hff, "status");
        dbg(FSL_ERASE, pa(127), FSL_GRANT);
        arm(32'h3);
        fw(FSL_ERASE, pa(127), pa(0), 8'hff, FSL_FERR);
        rst();
        arm(32'h1);
        fw(FSL_WRITE, 17'h1ffff, pa(3), 8'h80, FSL_GRANT);
        rst();
        rdc(OFS_STATUS, 32'h7f80, "status");
        for (int i = 0; i < 4; i++) begin
            dbg(FSL_READ, pa(i * 42), FSL_REFUSE);
        end
        dbg(FSL_DEV_ERASE, pa(0), FSL_GRANT);
        repeat (4) @(posedge hclk);
        chk(exp_q.size(), 32'h0, "pending");
        end_of_test();
    end
endmodule
